// *** rtl/asp_pkg.sv ***
// shared constants and carrier types of the serial host status port
package asp_pkg;
	// register select codes (register_select_high, register_select_low)
	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	// status bit positions
	localparam int ST_PARITY = 0;
	localparam int ST_FRAMING = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_RX_FULL = 3;
	localparam int ST_TX_EMPTY = 4;
	localparam int ST_CARRIER = 5;
	localparam int ST_DSR = 6;
	localparam int ST_IRQ = 7;
	// status after hardware reset: only transmit-empty set
	localparam logic [7:0] STATUS_RESET = 8'h10;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// word length code to data mask: 8, 7, 6, 5 bits
	localparam logic [1:0] WL_8 = 2'h0;
	localparam logic [1:0] WL_7 = 2'h1;
	localparam logic [1:0] WL_6 = 2'h2;
	localparam logic [1:0] WL_5 = 2'h3;
	localparam logic [7:0] MASK_8 = 8'hff;
	localparam logic [7:0] MASK_7 = 8'h7f;
	localparam logic [7:0] MASK_6 = 8'h3f;
	localparam logic [7:0] MASK_5 = 8'h1f;
	// transmitter interrupt control code that enables the interrupt
	localparam logic [1:0] TIC_IRQ_ON = 2'h1;
	// input synchroniser depth
	localparam int SYNC_STAGES = 3;

	// one sample of the processor bus pins
	typedef struct packed {
		logic cs;
		logic rnw;
		logic [1:0] sel;
		logic [7:0] data;
	} asp_bus_s;

	// character handed over by the receive shifter
	typedef struct packed {
		logic [7:0] data;
		logic framingErr;
		logic parityErr;
	} asp_rxchar_s;
endpackage

// *** rtl/asp_two_entry_buf.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asp_two_entry_buf #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] mem_r [2];
	logic [WIDTH-1:0] mem_nxt [2];
	logic wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [1:0] count_r, count_nxt;
	logic push, pop;

	assign inReady = (count_r != 2'h2);
	assign outValid = (count_r != 2'h0);
	assign outData = mem_r[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		mem_nxt = mem_r;
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (push) begin
			mem_nxt[wrPtr_r] = inData;
			wrPtr_nxt = ~wrPtr_r;
		end
		if (pop) begin
			rdPtr_nxt = ~rdPtr_r;
		end
		case ({push, pop})
			2'b10: count_nxt = count_r + 2'h1;
			2'b01: count_nxt = count_r - 2'h1;
			default: count_nxt = count_r;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			mem_r <= mem_nxt;
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end
endmodule
`default_nettype wire

// *** rtl/asp_host_status_port.sv ***
// processor bus side of the serial adapter: holding registers and status
`timescale 1ns/1ps
`default_nettype none
module asp_host_status_port (
	// clock and hardware reset (reset_low)
	input wire logic sys_clk,
	input wire logic rst_b,
	// processor bus pins
	input wire logic phaseTwoClk,
	input wire logic chipSelect,
	input wire logic readNotWrite,
	input wire logic registerSelectLow,
	input wire logic registerSelectHigh,
	input wire logic [7:0] busDataIn,
	output logic [7:0] busDataOut,
	output logic busDataOe,
	// open-drain interrupt request, low when active
	output logic irqRequestOut,
	output logic irqRequestOe,
	// modem status pins
	input wire logic dataSetReady,
	input wire logic carrierDetect,
	// command and control settings
	input wire logic terminalReady,
	input wire logic receiverIrqDisable,
	input wire logic [1:0] txIrqControl,
	input wire logic [1:0] wordLength,
	input wire logic programReset,
	// transmit shifter side
	output logic txValid,
	input wire logic txReady,
	output logic [7:0] txData,
	// receive shifter side
	input wire logic rxValid,
	input wire asp_pkg::asp_rxchar_s rxChar,
	// register strobe for the command and control registers
	output logic extWrite,
	output logic [1:0] extSelect,
	output logic [7:0] extWriteData
);
	// pin synchronisers: bus bundle, phase two, modem lines
	localparam int SW = $bits(asp_pkg::asp_bus_s) + 3;
	logic [SW-1:0] sync_r [asp_pkg::SYNC_STAGES];
	logic [SW-1:0] pinNow;
	asp_pkg::asp_bus_s bus2, bus3;
	logic ph2s2, ph2s3, dsr2, dsr3, dcd2, dcd3;

	assign pinNow = {chipSelect, readNotWrite,
		registerSelectHigh, registerSelectLow, busDataIn,
		phaseTwoClk, dataSetReady, carrierDetect};
	assign {bus2, ph2s2, dsr2, dcd2} = sync_r[1];
	assign {bus3, ph2s3, dsr3, dcd3} = sync_r[2];

	// stage one feeds only stage two; a metastable sample stays there
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < asp_pkg::SYNC_STAGES; i++) begin
				sync_r[i] <= '0;
			end
		end else begin
			sync_r[0] <= pinNow;
			for (int i = 1; i < asp_pkg::SYNC_STAGES; i++) begin
				sync_r[i] <= sync_r[i-1];
			end
		end
	end

	// filtered levels: change only when stages two and three agree
	logic ph2High_r, ph2High_nxt, dsrLvl_r, dsrLvl_nxt;
	logic dcdLvl_r, dcdLvl_nxt;
	logic ph2Rise, ph2Fall;

	always_comb begin
		ph2High_nxt = (ph2s2 == ph2s3) ? ph2s3 : ph2High_r;
		dsrLvl_nxt = (dsr2 == dsr3) ? dsr3 : dsrLvl_r;
		dcdLvl_nxt = (dcd2 == dcd3) ? dcd3 : dcdLvl_r;
	end
	assign ph2Rise = ph2High_nxt && !ph2High_r;
	assign ph2Fall = !ph2High_nxt && ph2High_r;

	// bus decode
	logic selHit, rdData, rdStatus, wrData, wrStatus, wrOther;
	assign selHit = bus3.cs && ph2High_r;
	assign rdData = selHit && ph2Fall && bus3.rnw &&
		bus3.sel == asp_pkg::SEL_DATA;
	assign rdStatus = selHit && ph2Fall && bus3.rnw &&
		bus3.sel == asp_pkg::SEL_STATUS;
	assign wrData = selHit && ph2Fall && !bus3.rnw &&
		bus3.sel == asp_pkg::SEL_DATA;
	// a status write is the program reset strobe
	assign wrStatus = selHit && ph2Fall && !bus3.rnw &&
		bus3.sel == asp_pkg::SEL_STATUS;
	assign wrOther = selHit && ph2Fall && !bus3.rnw && bus3.sel[1];

	// transmit path through the two-entry buffer
	logic bufInReady, bufOutValid, txMove;
	logic [7:0] bufOut, txMask;
	assign txMove = bufOutValid && txReady;

	asp_two_entry_buf #(
		.WIDTH(8)
	) u_txbuf (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.inValid(wrData),
		.inReady(bufInReady),
		.inData(bus3.data),
		.outValid(bufOutValid),
		.outReady(txReady),
		.outData(bufOut)
	);

	function automatic logic [7:0] wlMask(input logic [1:0] wl);
		case (wl)
			asp_pkg::WL_8: wlMask = asp_pkg::MASK_8;
			asp_pkg::WL_7: wlMask = asp_pkg::MASK_7;
			asp_pkg::WL_6: wlMask = asp_pkg::MASK_6;
			default: wlMask = asp_pkg::MASK_5;
		endcase
	endfunction

	assign txMask = wlMask(wordLength);
	assign txValid = bufOutValid;
	assign txData = bufOut & txMask;

	// status and receive state
	logic [7:0] rxHold_r, rxHold_nxt, rdLatch_r, rdLatch_nxt;
	logic rxFull_r, rxFull_nxt, txEmpty_r, txEmpty_nxt;
	logic ovr_r, ovr_nxt, fe_r, fe_nxt, pe_r, pe_nxt;
	logic irq_r, irq_nxt, modemHeld_r, modemHeld_nxt;
	logic dsrStat_r, dsrStat_nxt, dcdStat_r, dcdStat_nxt;
	logic rxIrqEn, txIrqEn, modemChange, rxLoad;
	logic [7:0] status;

	assign status = {irq_r, dsrStat_r, dcdStat_r, txEmpty_r,
		rxFull_r, ovr_r, fe_r, pe_r};

	assign rxIrqEn = !receiverIrqDisable && terminalReady;
	assign txIrqEn = terminalReady &&
		txIrqControl == asp_pkg::TIC_IRQ_ON;
	assign modemChange = !modemHeld_r &&
		(dsrLvl_r != dsrStat_r || dcdLvl_r != dcdStat_r);
	// a data read in the same cycle frees the register: new char loads
	assign rxLoad = rxValid && (!rxFull_r || rdData);

	always_comb begin
		rxHold_nxt = rxHold_r;
		rxFull_nxt = rxFull_r;
		txEmpty_nxt = txEmpty_r;
		ovr_nxt = ovr_r;
		fe_nxt = fe_r;
		pe_nxt = pe_r;
		irq_nxt = irq_r;
		modemHeld_nxt = modemHeld_r;
		dsrStat_nxt = dsrStat_r;
		dcdStat_nxt = dcdStat_r;
		rdLatch_nxt = rdLatch_r;
		// clears first, hardware sets below win
		if (rdData) begin
			rxFull_nxt = 1'b0;
			ovr_nxt = 1'b0;
			fe_nxt = 1'b0;
			pe_nxt = 1'b0;
		end
		if (rdStatus) begin
			irq_nxt = 1'b0;
			// releases held modem levels; next change interrupts again unless receiverIrqDisable is set
			modemHeld_nxt = 1'b0;
		end
		if (wrStatus || programReset) begin
			ovr_nxt = 1'b0;
		end
		if (wrData && bufInReady) begin
			txEmpty_nxt = 1'b0;
		end
		// set on every move without a data write in the same cycle, even with a second word queued
		if (txMove && !wrData) begin
			txEmpty_nxt = 1'b1;
			if (txIrqEn) begin
				irq_nxt = 1'b1;
			end
		end
		if (rxLoad) begin
			// parity already removed by the shifter, upper bits zeroed
			rxHold_nxt = rxChar.data & wlMask(wordLength);
			rxFull_nxt = 1'b1;
			fe_nxt = rxChar.framingErr;
			pe_nxt = rxChar.parityErr;
			if (rxIrqEn) begin
				irq_nxt = 1'b1;
			end
		end else if (rxValid && !rdData) begin
			ovr_nxt = 1'b1;
		end
		if (modemChange) begin
			dsrStat_nxt = dsrLvl_r;
			dcdStat_nxt = dcdLvl_r;
			modemHeld_nxt = 1'b1;
			if (!receiverIrqDisable) begin
				irq_nxt = 1'b1;
			end
		end
		if (ph2Rise) begin
			rdLatch_nxt = (bus2.sel == asp_pkg::SEL_DATA) ? rxHold_r
				: status;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph2High_r <= 1'b0;
			dsrLvl_r <= 1'b0;
			dcdLvl_r <= 1'b0;
			rxHold_r <= asp_pkg::DATA_RESET;
			rdLatch_r <= asp_pkg::DATA_RESET;
			rxFull_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_RX_FULL];
			txEmpty_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_TX_EMPTY];
			ovr_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_OVERRUN];
			fe_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_FRAMING];
			pe_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_PARITY];
			irq_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_IRQ];
			dsrStat_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_DSR];
			dcdStat_r <= asp_pkg::STATUS_RESET[asp_pkg::ST_CARRIER];
			modemHeld_r <= 1'b0;
		end else begin
			ph2High_r <= ph2High_nxt;
			dsrLvl_r <= dsrLvl_nxt;
			dcdLvl_r <= dcdLvl_nxt;
			rxHold_r <= rxHold_nxt;
			rdLatch_r <= rdLatch_nxt;
			rxFull_r <= rxFull_nxt;
			txEmpty_r <= txEmpty_nxt;
			ovr_r <= ovr_nxt;
			fe_r <= fe_nxt;
			pe_r <= pe_nxt;
			irq_r <= irq_nxt;
			dsrStat_r <= dsrStat_nxt;
			dcdStat_r <= dcdStat_nxt;
			modemHeld_r <= modemHeld_nxt;
		end
	end

	// bus drive: only reads of the two local registers drive the pins
	assign busDataOut = rdLatch_r;
	assign busDataOe = selHit && bus3.rnw && !bus3.sel[1];
	// open drain: drive low only while the interrupt bit stands
	assign irqRequestOut = 1'b0;
	assign irqRequestOe = irq_r;

	// command and control register writes go outside
	logic extWrite_r, extWrite_nxt;
	logic [1:0] extSelect_r, extSelect_nxt;
	logic [7:0] extData_r, extData_nxt;

	always_comb begin
		extWrite_nxt = wrOther;
		extSelect_nxt = wrOther ? bus3.sel : extSelect_r;
		extData_nxt = wrOther ? bus3.data : extData_r;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			extWrite_r <= 1'b0;
			extSelect_r <= 2'h0;
			extData_r <= asp_pkg::DATA_RESET;
		end else begin
			extWrite_r <= extWrite_nxt;
			extSelect_r <= extSelect_nxt;
			extData_r <= extData_nxt;
		end
	end

	assign extWrite = extWrite_r;
	assign extSelect = extSelect_r;
	assign extWriteData = extData_r;
endmodule
`default_nettype wire

// *** verif/asp_host_status_port_monitor.sv ***
// checker of the host status port bus, irq and transmit pins
`timescale 1ns/1ps
`default_nettype none
module asp_host_status_port_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// bus pins
	input wire logic chipSelect,
	input wire logic readNotWrite,
	input wire logic registerSelectHigh,
	input wire logic busDataOe,
	// interrupt and command levels
	input wire logic irqRequestOut,
	input wire logic irqRequestOe,
	input wire logic terminalReady,
	input wire logic receiverIrqDisable,
	// transmit and register strobe side
	input wire logic txValid,
	input wire logic txReady,
	input wire logic [7:0] txData,
	input wire logic [1:0] wordLength,
	input wire logic extWrite,
	input wire logic [1:0] extSelect
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_oe_read;
		busDataOe |-> chipSelect && readNotWrite;
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("bad drive");
	property p_oe_sel;
		busDataOe |-> !registerSelectHigh;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("bad select");
	property p_irq_low;
		irqRequestOe |-> !irqRequestOut;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq level");
	property p_irq_cause;
		$rose(irqRequestOe) |-> terminalReady || !receiverIrqDisable;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq gate");
	property p_tx_hold;
		txValid && !txReady |=> txValid && $stable(txData);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx lost");
	// high bits beyond the word length must never reach the shifter
	property p_tx_mask;
		txValid |-> (txData >> (4'h8 - wordLength)) == 8'h00;
	endproperty
	a_tx_mask: assert property (p_tx_mask) else $error("tx mask");
	property p_ext_pulse;
		extWrite |=> !extWrite;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse) else $error("ext pulse");
	property p_ext_sel;
		extWrite |-> extSelect[1] && !readNotWrite;
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("ext select");
	c_irq: cover property ($rose(irqRequestOe));
	c_pop: cover property (txValid && txReady);
	c_ext: cover property (extWrite);
endmodule
bind asp_host_status_port asp_host_status_port_monitor i_mon (.*);
`default_nettype wire

// *** verif/asp_cpu_model.sv ***
// processor side model running phase two bus cycles
`timescale 1ns/1ps
`default_nettype none
module asp_cpu_model (
	// clock
	input wire logic sys_clk,
	// bus pins towards the port
	output logic phaseTwoClk,
	output logic chipSelect,
	output logic readNotWrite,
	output logic [1:0] sel,
	output logic [7:0] dataOut,
	input wire logic [7:0] dataIn,
	input wire logic dataOe
);
	initial begin
		phaseTwoClk = 1'b0;
		chipSelect = 1'b0;
		readNotWrite = 1'b1;
		sel = 2'h0;
		dataOut = 8'h00;
	end
	// pins held past the filtered fall, since the port commits late
	task automatic xfer(input logic rnw, input logic [1:0] s,
		input logic [7:0] wd, output logic [7:0] rd);
		rd = 8'hxx;
		@(posedge sys_clk);
		#1;
		chipSelect = 1'b1;
		readNotWrite = rnw;
		sel = s;
		dataOut = rnw ? ~dataOut : wd;
		phaseTwoClk = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		if (dataOe === 1'b1)
			rd = dataIn;
		phaseTwoClk = 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		chipSelect = 1'b0;
		dataOut = ~dataOut;
	endtask
endmodule
`default_nettype wire

// *** verif/asp_host_status_port_bench.sv ***
// self-checking bench of the host status port
`timescale 1ns/1ps
`default_nettype none
module asp_host_status_port_bench;
	logic sys_clk, rst_b, phi, cs, rnw, oe, irqOut, irqOe, dsr, dcd;
	logic dtr, receiver_irq_disable, txReady, txValid, rxValid, extWrite, progRst;
	logic [1:0] sel, tic, wl, extSelect;
	logic [7:0] dOut, dIn, txData, extWriteData;
	asp_pkg::asp_rxchar_s rxChar;
	int errCount, compares, extCount;
	asp_cpu_model i_cpu (.sys_clk(sys_clk), .phaseTwoClk(phi),
		.chipSelect(cs), .readNotWrite(rnw), .sel(sel), .dataOut(dOut),
		.dataIn(dIn), .dataOe(oe));
	asp_host_status_port i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.phaseTwoClk(phi), .chipSelect(cs), .readNotWrite(rnw),
		.registerSelectLow(sel[0]), .registerSelectHigh(sel[1]),
		.busDataIn(dOut), .busDataOut(dIn), .busDataOe(oe),
		.irqRequestOut(irqOut), .irqRequestOe(irqOe),
		.dataSetReady(dsr), .carrierDetect(dcd), .terminalReady(dtr),
		.receiverIrqDisable(receiver_irq_disable), .txIrqControl(tic), .wordLength(wl),
		.programReset(progRst), .txValid(txValid), .txReady(txReady),
		.txData(txData), .rxValid(rxValid), .rxChar(rxChar),
		.extWrite(extWrite), .extSelect(extSelect),
		.extWriteData(extWriteData));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// strobe pulses counted away from the edge that launches them
	always @(negedge sys_clk) begin
		if (extWrite === 1'b1)
			extCount++;
	end
	task automatic endSim();
		$display("compares=%0d mismatches=%0d", compares, errCount);
		if (errCount == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			errCount++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [1:0] s, input logic [7:0] exp);
		logic [7:0] v;
		i_cpu.xfer(1'b1, s, 8'h00, v);
		chk(v, exp);
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		logic [7:0] v;
		i_cpu.xfer(1'b0, s, d, v);
	endtask
	task automatic rs(input logic [7:0] exp);
		rd(asp_pkg::SEL_STATUS, exp);
	endtask
	task automatic rx(input logic [9:0] c);
		rxChar = c;
		rxValid = 1'b1;
		tick(1);
		rxValid = 1'b0;
		tick(3);
	endtask
	task automatic pop();
		txReady = 1'b1;
		tick(1);
		txReady = 1'b0;
	endtask
	task automatic tReset();
		chk({7'h0, irqOe}, 8'h00);
		rs(asp_pkg::STATUS_RESET);
		$display("test reset done");
	endtask
	// receiver irq stays off here so only transmit events count
	task automatic tTx();
		wl = asp_pkg::WL_5;
		tic = asp_pkg::TIC_IRQ_ON;
		dtr = 1'b1;
		wr(asp_pkg::SEL_DATA, 8'hff);
		wr(asp_pkg::SEL_DATA, 8'ha5);
		rs(8'h00);
		chk({7'h0, txValid}, 8'h01);
		chk(txData, 8'h1f);
		pop();
		chk(txData, 8'h05);
		pop();
		tick(2);
		chk({7'h0, irqOe}, 8'h01);
		chk({7'h0, irqOut}, 8'h00);
		chk({7'h0, txValid}, 8'h00);
		rs(8'h90);
		rs(8'h10);
		tic = 2'h0;
		$display("test transmit done");
	endtask
	task automatic tRx();
		wl = asp_pkg::WL_8;
		receiver_irq_disable = 1'b0;
		rx({8'h3c, 2'b10});
		rs(8'h9a);
		rx({8'h55, 2'b00});
		chk({7'h0, irqOe}, 8'h00);
		rs(8'h1e);
		wr(asp_pkg::SEL_STATUS, 8'h00);
		rs(8'h1a);
		rd(asp_pkg::SEL_DATA, 8'h3c);
		rs(8'h10);
		// five-bit words: upper bits of the holding register read zero
		wl = asp_pkg::WL_5;
		rx({8'hff, 2'b01});
		rs(8'h99);
		rx({8'h00, 2'b00});
		rs(8'h1d);
		progRst = 1'b1;
		tick(1);
		progRst = 1'b0;
		rs(8'h19);
		rd(asp_pkg::SEL_DATA, 8'h1f);
		rs(8'h10);
		$display("test receive done");
	endtask
	task automatic tModem();
		dsr = 1'b1;
		tick(10);
		chk({7'h0, irqOe}, 8'h01);
		dcd = 1'b1;
		tick(10);
		rs(8'hd0);
		rs(8'hf0);
		rs(8'h70);
		receiver_irq_disable = 1'b1;
		dsr = 1'b0;
		tick(10);
		rs(8'h30);
		$display("test modem done");
	endtask
	task automatic tExt();
		wr(2'h2, 8'h5a);
		chk({6'h0, extSelect}, 8'h02);
		chk(extWriteData, 8'h5a);
		chk(extCount[7:0], 8'h01);
		rd(2'h3, 8'hxx);
		$display("test ext done");
	endtask
	initial begin
		errCount = 0;
		compares = 0;
		extCount = 0;
		progRst = 1'b0;
		rst_b = 1'b0;
		{dsr, dcd, dtr, txReady, rxValid} = 5'h00;
		receiver_irq_disable = 1'b1;
		{tic, wl} = 4'h0;
		rxChar = 10'h000;
		repeat (20) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		tick(4);
		tReset();
		tTx();
		tRx();
		tModem();
		tExt();
		endSim();
	end
	initial begin
		#100000;
		errCount++;
		endSim();
	end
endmodule
`default_nettype wire
